/* solenoid_load_model.sv */
// Far-side model: enable pin with pull-up and a gate timing meter.
// Assumes the gate is sampled on the sequencer clock.
`timescale 1ns/10ps
`default_nettype none
module solenoid_load_model (
	// Clock
	input wire logic i_clk,
	// Host and gate
	input wire logic i_pull_low,
	input wire logic i_gate,
	// Pin and meter
	output logic o_enable_pin,
	output var logic [15:0] o_high_cycles,
	output var logic [15:0] o_period_cycles
);
	logic gate_q;
	logic [15:0] run_q;
	logic [15:0] per_q;
	////////////////////////////////////////////////////////////
	// Open-drain host, pull-up
	// A host only sinks the pin, so it idles high
	assign o_enable_pin = i_pull_low ? 1'b0 : 1'b1;
	// Meter: high samples per pulse, cycles between rises
	always_ff @(posedge i_clk) begin
		gate_q <= i_gate;
		if (i_gate && !gate_q) begin
			o_period_cycles <= per_q;
			per_q <= 16'h1;
			run_q <= 16'h1;
		end else begin
			per_q <= per_q + 16'h1;
			if (i_gate) begin
				run_q <= run_q + 16'h1;
			end
		end
		if (!i_gate && gate_q) begin
			o_high_cycles <= run_q;
		end
	end
endmodule
`default_nettype wire

/* solenoid_params.svh */
// Constants for the solenoid phase sequencer: timing counts and duty codes.
// Assumes a 40 MHz system clock standing in for the internal oscillator.
// Behaviour
// [RULE1] Energise delay timed by digital cycle divider
// [RULE2] Energise delay lasts nominal 136 ms
// [RULE3] Start delay at reset, auto switch hold
// [RULE4] Overtemperature keeps output stage off always
// [RULE5] After overtemperature, restart from energise phase
// [RULE6] DC variant: hold selects hold resistor
// [RULE7] PWM period nominal 30 kHz from clock
// [RULE8] External duty code sets 20-90% high time
// [RULE9] Duty tied to rail gives fixed 50%
// [RULE10] Enable low stops, high restarts sequence
// [RULE11] Enable pulled up; host open-drain or 3.3V
// [RULE12] Idle high enable means running state
// [RULE13] PWM gate fully on during energise
`ifndef SOLENOID_PARAMS_SVH
`define SOLENOID_PARAMS_SVH

`define CLK_HZ 40000000
`define DELAY_MS 136
`define DELAY_CYCLES ((`CLK_HZ / 1000) * `DELAY_MS)
`define PWM_HZ 30000
`define PWM_CYCLES (`CLK_HZ / `PWM_HZ)
`define DUTY_MIN_PCT 20
`define DUTY_MAX_PCT 90
`define DUTY_FIX_PCT 50

`endif

/* solenoid_phase_sequencer_pwm.sv */
// Energise/hold sequencer for a low-side solenoid driver, both variants.
// Assumes enable, overtemp and duty-rail inputs arrive asynchronously;
// the duty code comes from an on-chip converter on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "solenoid_params.svh"
module solenoid_phase_sequencer_pwm #(
	parameter int DELAY_CYCLES = `DELAY_CYCLES,
	parameter int PWM_CYCLES = `PWM_CYCLES,
	parameter bit PWM_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Pins and analog flags
	input wire logic i_enable_input_pin,
	input wire logic i_overtemp,
	input wire logic i_duty_at_rail,
	input wire logic [6:0] i_duty_pct,
	// Outputs
	output logic o_gate,
	output logic o_hold_ref_sel,
	output logic o_hold_phase
);
	localparam int DW = $clog2(DELAY_CYCLES + 1);
	initial begin
		if (DELAY_CYCLES < 2) $error("Delay too short");
	end

	////////////////////////////////////////////////////////////////////
	// Input synchronisers
	// [RULE11] Enable pin pulled up off-block, idles high
	logic [1:0] en_s_q, ot_s_q, rail_s_q;
	always_ff @(posedge i_clk) begin
		en_s_q <= {en_s_q[0], i_enable_input_pin};
		ot_s_q <= {ot_s_q[0], i_overtemp};
		rail_s_q <= {rail_s_q[0], i_duty_at_rail};
	end
	wire en_ok = en_s_q[1];
	wire ot = ot_s_q[1];
	wire rail = rail_s_q[1];

	////////////////////////////////////////////////////////////////////
	// Phase sequencer
	solenoid_pkg::phase_t st_q, st_d;
	logic [DW-1:0] dly_q;
	// [RULE12] High enable level means run, low forces off
	wire stop = !en_ok || ot;
	// [RULE2] Terminal count fixes energise length
	wire dly_done = (dly_q == DW'(DELAY_CYCLES - 1));
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			solenoid_pkg::ST_OFF: begin
				// [RULE5] Restart from energise after stop clears
				if (!stop) st_d = solenoid_pkg::ST_ENERGISE;
			end
			solenoid_pkg::ST_ENERGISE: begin
				// [RULE3] Automatic change to hold
				if (stop) st_d = solenoid_pkg::ST_OFF;
				else if (dly_done) st_d = solenoid_pkg::ST_HOLD;
			end
			solenoid_pkg::ST_HOLD: begin
				if (stop) st_d = solenoid_pkg::ST_OFF;
			end
		endcase
	end
	// [RULE10] Enable low stops, return restarts sequence
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= solenoid_pkg::ST_OFF;
		end else begin
			st_q <= st_d;
		end
	end
	// [RULE1] Digital delay divider, fresh each energise
	always_ff @(posedge i_clk) begin
		if (i_rst || st_q != solenoid_pkg::ST_ENERGISE) begin
			dly_q <= '0;
		end else if (!dly_done) begin
			dly_q <= dly_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Duty selection and PWM
	logic [6:0] duty_lim;
	logic pwm;
	// [RULE8] Clamp external duty into 20..90 percent
	assign duty_lim = (i_duty_pct < 7'(`DUTY_MIN_PCT)) ? 7'(`DUTY_MIN_PCT) :
		(i_duty_pct > 7'(`DUTY_MAX_PCT)) ? 7'(`DUTY_MAX_PCT) : i_duty_pct;
	// [RULE9] Rail-tied duty pin picks fixed 50 percent
	wire [6:0] duty_sel = rail ? 7'(`DUTY_FIX_PCT) : duty_lim;
	wire hold = (st_q == solenoid_pkg::ST_HOLD);
	solenoid_pwm #(
		.PERIOD(PWM_CYCLES)
	) u_pwm (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(hold),
		.i_duty_pct(duty_sel),
		.o_pwm(pwm)
	);

	////////////////////////////////////////////////////////////////////
	// Output stage, registered
	// Gate is gated again by stop so overtemp acts one cycle sooner
	wire gate_d = !stop && (st_q == solenoid_pkg::ST_ENERGISE ||
		(hold && (!PWM_VARIANT || pwm)));
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_gate <= 1'b0;
			o_hold_ref_sel <= 1'b0;
			o_hold_phase <= 1'b0;
		end else begin
			// [RULE4] Overtemp disables output
			// [RULE13] Energise keeps gate fully on
			o_gate <= gate_d;
			// [RULE6] Hold selects hold resistor reference
			o_hold_ref_sel <= hold && !PWM_VARIANT;
			o_hold_phase <= hold;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_energise_done;
		st_q == solenoid_pkg::ST_ENERGISE && dly_done && !stop;
	endsequence
	property p_ot_off;
		@(posedge i_clk) disable iff (i_rst) ot |=> !o_gate;
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("gate on in overtemp"); // [RULE4]
	property p_to_hold;
		@(posedge i_clk) disable iff (i_rst) s_energise_done |=> ##1 o_hold_phase;
	endproperty
	a_to_hold: assert property (p_to_hold) else $error("no hold after delay"); // [RULE3]
	property p_restart;
		@(posedge i_clk) disable iff (i_rst)
			$fell(stop) |=> st_q == solenoid_pkg::ST_ENERGISE && dly_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("no fresh energise"); // [RULE5]
	property p_delay_len;
		@(posedge i_clk) disable iff (i_rst)
			st_q == solenoid_pkg::ST_HOLD && $past(st_q) == solenoid_pkg::ST_ENERGISE
			|-> $past(dly_q) == DW'(DELAY_CYCLES - 1);
	endproperty
	a_delay_len: assert property (p_delay_len) else $error("delay length wrong"); // [RULE2]
	property p_divider;
		@(posedge i_clk) disable iff (i_rst)
			st_q == solenoid_pkg::ST_ENERGISE && $past(st_q) == solenoid_pkg::ST_ENERGISE
			&& !$past(dly_done) |-> dly_q == $past(dly_q) + 1'b1;
	endproperty
	a_divider: assert property (p_divider) else $error("divider stalled"); // [RULE1]
	property p_en_off;
		@(posedge i_clk) disable iff (i_rst) !en_ok |=> !o_gate ##1 !o_hold_phase;
	endproperty
	a_en_off: assert property (p_en_off) else $error("enable low not off"); // [RULE10]
	property p_idle_run;
		@(posedge i_clk) disable iff (i_rst)
			en_ok && !ot && st_q == solenoid_pkg::ST_OFF |=> st_q == solenoid_pkg::ST_ENERGISE;
	endproperty
	a_idle_run: assert property (p_idle_run) else $error("high enable not running"); // [RULE12]
	property p_energise_on;
		@(posedge i_clk) disable iff (i_rst)
			st_q == solenoid_pkg::ST_ENERGISE && !stop |=> o_gate;
	endproperty
	a_energise_on: assert property (p_energise_on) else $error("gate off in energise"); // [RULE13]
	property p_ref_sel;
		@(posedge i_clk) disable iff (i_rst) o_hold_ref_sel |-> !PWM_VARIANT && o_hold_phase;
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("hold reference wrong"); // [RULE6]
	property p_fixed_duty;
		@(posedge i_clk) disable iff (i_rst) rail |-> duty_sel == 7'(`DUTY_FIX_PCT);
	endproperty
	a_fixed_duty: assert property (p_fixed_duty) else $error("fixed duty not 50"); // [RULE9]
	property p_duty_range;
		@(posedge i_clk) disable iff (i_rst)
			!rail |-> duty_sel >= 7'(`DUTY_MIN_PCT) && duty_sel <= 7'(`DUTY_MAX_PCT);
	endproperty
	a_duty_range: assert property (p_duty_range) else $error("duty out of range"); // [RULE8]

	////////////////////////////////////////////////////////////////////
	// Phase and output checks, same cycle or one cycle after the sampled state
	// Reset leaves every output low
	property p_rst_quiet;
		@(posedge i_clk)
		i_rst |=> !o_gate && !o_hold_phase && !o_hold_ref_sel;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs up after reset"); // [RULE3]

	// Off with no stop enters energise with a fresh count
	property p_entry;
		@(posedge i_clk) disable iff (i_rst)
		st_q == solenoid_pkg::ST_OFF && !stop |=> st_q == solenoid_pkg::ST_ENERGISE && dly_q == '0;
	endproperty
	a_entry: assert property (p_entry) else $error("no energise entry"); // [RULE3]

	// Counter cleared outside energise, so each entry starts fresh
	property p_dly_idle;
		@(posedge i_clk) disable iff (i_rst)
		st_q != solenoid_pkg::ST_ENERGISE |=> dly_q == '0;
	endproperty
	a_dly_idle: assert property (p_dly_idle) else $error("divider not cleared"); // [RULE1]

	// Counter never runs past its terminal count
	property p_dly_bound;
		@(posedge i_clk) disable iff (i_rst)
		dly_q <= DW'(DELAY_CYCLES - 1);
	endproperty
	a_dly_bound: assert property (p_dly_bound) else $error("divider overran"); // [RULE2]

	// Any stop reason drops the sequence to off
	property p_stop_off;
		@(posedge i_clk) disable iff (i_rst)
		stop |=> st_q == solenoid_pkg::ST_OFF;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop not honoured"); // [RULE4]

	// Off never jumps straight to hold
	property p_no_skip;
		@(posedge i_clk) disable iff (i_rst)
		st_q == solenoid_pkg::ST_OFF |=> st_q != solenoid_pkg::ST_HOLD;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("energise skipped"); // [RULE5]

	// Hold is kept while nothing stops it
	property p_hold_keeps;
		@(posedge i_clk) disable iff (i_rst)
		hold && !stop |=> hold;
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("hold left early"); // [RULE3]

	// Hold flag output trails the state by one register
	property p_hold_flag;
		@(posedge i_clk) disable iff (i_rst)
		hold |=> o_hold_phase;
	endproperty
	a_hold_flag: assert property (p_hold_flag) else $error("hold flag missing"); // [RULE3]

	// DC variant sinks steadily through hold
	property p_dc_steady;
		@(posedge i_clk) disable iff (i_rst)
		!PWM_VARIANT && hold && !stop |=> o_gate;
	endproperty
	a_dc_steady: assert property (p_dc_steady) else $error("dc gate dropped"); // [RULE6]

	// Switching variant gate follows the PWM one register late
	property p_pwm_follow;
		@(posedge i_clk) disable iff (i_rst)
		PWM_VARIANT && hold && !stop |=> o_gate == $past(pwm);
	endproperty
	a_pwm_follow: assert property (p_pwm_follow) else $error("gate not pwm"); // [RULE7]

	// PWM quiet outside hold, so energise is a plain on level
	property p_pwm_idle;
		@(posedge i_clk) disable iff (i_rst)
		!hold |=> !pwm;
	endproperty
	a_pwm_idle: assert property (p_pwm_idle) else $error("pwm outside hold"); // [RULE13]

	// Gate only ever follows an active phase
	property p_gate_phase;
		@(posedge i_clk) disable iff (i_rst)
		o_gate |-> $past(st_q) != solenoid_pkg::ST_OFF;
	endproperty
	a_gate_phase: assert property (p_gate_phase) else $error("gate on while off"); // [RULE4]

	// Enable back and staying up: energise, then gate on
	sequence s_en_back;
		$rose(en_ok) && !ot ##1 !stop;
	endsequence
	property p_en_back;
		@(posedge i_clk) disable iff (i_rst)
		s_en_back |-> st_q == solenoid_pkg::ST_ENERGISE ##1 o_gate;
	endproperty
	a_en_back: assert property (p_en_back) else $error("enable did not restart"); // [RULE10]

	// An in-range code passes through untouched
	property p_duty_pass;
		@(posedge i_clk) disable iff (i_rst)
		!rail && i_duty_pct >= 7'(`DUTY_MIN_PCT) && i_duty_pct <= 7'(`DUTY_MAX_PCT)
		|-> duty_sel == i_duty_pct;
	endproperty
	a_duty_pass: assert property (p_duty_pass) else $error("duty code altered"); // [RULE8]

	// Switching variant has no current reference to swap
	property p_ref_off;
		@(posedge i_clk) disable iff (i_rst)
		PWM_VARIANT |-> !o_hold_ref_sel;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference in pwm variant"); // [RULE6]

	// DC variant swaps to the hold resistor on hold entry
	property p_ref_on;
		@(posedge i_clk) disable iff (i_rst)
		!PWM_VARIANT && hold |=> o_hold_ref_sel;
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("hold reference missing"); // [RULE6]
endmodule
`default_nettype wire

/* solenoid_pkg.sv */
// Types shared by the solenoid sequencer files.
// Assumes nothing beyond the params header.
package solenoid_pkg;
	typedef enum logic [1:0] {ST_OFF, ST_ENERGISE, ST_HOLD} phase_t;
endpackage

/* solenoid_pwm.sv */
// PWM gate generator: fixed period, duty in percent.
// Assumes the caller supplies a duty already limited to 0..100.
`timescale 1ns/10ps
`default_nettype none
`include "solenoid_params.svh"
module solenoid_pwm #(
	parameter int PERIOD = `PWM_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [6:0] i_duty_pct,
	// Gate
	output logic o_pwm
);
	localparam int CW = $clog2(PERIOD);
	logic [CW-1:0] cnt_q;
	logic [CW+7:0] thresh;
	initial begin
		if (PERIOD < 100) $error("PWM period too short");
	end
	// Threshold in clock cycles for the requested duty
	assign thresh = (CW + 8)'((CW + 8)'(PERIOD) * (CW + 8)'(i_duty_pct) / (CW + 8)'(100));
	// [RULE7] Period counter
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run || cnt_q == CW'(PERIOD - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	// [RULE8] High time compare
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run) begin
			o_pwm <= 1'b0;
		end else begin
			o_pwm <= ((CW + 8)'(cnt_q) < thresh);
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
// Bench for the sequencer: PWM and DC variants side by side.
// Assumes solenoid_load_model as the far side; short delay count.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int DLY = 50;
	localparam int PER = 100;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic pull_low = 1'b0;
	logic hot = 1'b0;
	logic rail = 1'b0;
	logic [6:0] duty = 7'h32;
	wire logic en_pin, gate, gate_dc, hold, hold_dc, sel_dc;
	wire logic [15:0] high_n, per_n;
	int fail_count = 0;
	int compares = 0;
	always #12.5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////
	solenoid_phase_sequencer_pwm #(.DELAY_CYCLES(DLY), .PWM_CYCLES(PER), .PWM_VARIANT(1'b1)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_enable_input_pin(en_pin), .i_overtemp(hot),
		.i_duty_at_rail(rail), .i_duty_pct(duty), .o_gate(gate), .o_hold_ref_sel(),
		.o_hold_phase(hold));
	solenoid_phase_sequencer_pwm #(.DELAY_CYCLES(DLY), .PWM_CYCLES(PER), .PWM_VARIANT(1'b0)) DUT_DC (
		.i_clk(i_clk), .i_rst(i_rst), .i_enable_input_pin(en_pin), .i_overtemp(hot),
		.i_duty_at_rail(rail), .i_duty_pct(duty), .o_gate(gate_dc), .o_hold_ref_sel(sel_dc),
		.o_hold_phase(hold_dc));
	solenoid_load_model LOAD (.i_clk(i_clk), .i_pull_low(pull_low), .i_gate(gate),
		.o_enable_pin(en_pin), .o_high_cycles(high_n), .o_period_cycles(per_n));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// Waits settle past the edge so outputs are read after update
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Energise must hold the gate on until the delay runs out
	task automatic t_restart();
		int n;
		n = 0;
		cyc(5);
		chk(gate === 1'b1 && gate_dc === 1'b1 && hold === 1'b0, "gate off in energise");
		while (hold !== 1'b1 && n < DLY + 10) begin
			chk(gate === 1'b1 && gate_dc === 1'b1 && sel_dc === 1'b0, "energise");
			cyc(1);
			n++;
		end
		chk(n >= DLY - 5 && n <= DLY + 2, "energise length");
		chk(hold_dc === 1'b1 && sel_dc === 1'b1, "dc hold reference");
	endtask
	// Three periods let a changed duty settle before measuring
	task automatic t_duty(input logic [6:0] d, input logic r, input int hi);
		@(posedge i_clk) begin
			duty <= d;
			rail <= r;
		end
		cyc(3 * PER + 4);
		chk(high_n === 16'(hi) && per_n === 16'(PER), "pwm high or period");
		chk(gate_dc === 1'b1 && hold === 1'b1, "hold lost");
	endtask
	// Off by enable pin or by overtemperature, then full restart
	task automatic t_off(input logic by_pin);
		@(posedge i_clk) if (by_pin) pull_low <= 1'b1; else hot <= 1'b1;
		cyc(4);
		repeat (20) begin
			chk(gate === 1'b0 && gate_dc === 1'b0, "output not off");
			chk(!by_pin || hold === 1'b0, "sequence not reset");
			cyc(1);
		end
		@(posedge i_clk) begin
			pull_low <= 1'b0;
			hot <= 1'b0;
		end
		t_restart();
	endtask
	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		cyc(4);
		@(posedge i_clk) i_rst <= 1'b0;
		t_restart();
		t_duty(7'h14, 1'b0, 20);
		t_duty(7'h37, 1'b0, 55);
		t_duty(7'h5A, 1'b0, 90);
		t_duty(7'h0A, 1'b0, 20);
		t_duty(7'h64, 1'b0, 90);
		t_duty(7'h5A, 1'b1, 50);
		t_off(1'b0);
		t_off(1'b1);
		finish_test();
	end
	// Watchdog: run needs about 2050 cycles
	initial begin
		#(25 * 20000);
		fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
